// [src/cwmc_top.sv]
// Behaviour
// - come up in sleep after reset
// - sleep stops the controller clock
// - sleep request enters sleep, sets flag
// - auto wakeup on bus activity leaves sleep
// - clearing sleep request leaves sleep
// - sleep to init on init request
// - sleep to normal when both cleared
// - init request enters init, sets flag
// - init to sleep on sleep request
// - init to normal when both cleared
// - three mailboxes with transmit scheduler
// - two hardware FIFOs, three messages each
// - 28 filter banks accept or discard
// - FD frames up to 64 bytes
// - bit rate limits 1 and 6 Mbit/s
// - no automatic retransmit in time-triggered mode
// - 16-bit timer stamps every SOF
// - timestamp into last two bytes in time-triggered mode
// - transmitter delay compensation for data phase
// - finish frame before normal to sleep
// - finish frame before normal to init
`default_nettype none
module cwmc_top
  import cwmc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic can_rx_i,
  input wire logic eng_busy_i,
  input wire logic rx_sof_i,
  input wire logic tx_sof_i,
  input wire logic rx_valid_i,
  input wire cwmc_rx_frame_t rx_frame_i,
  input wire logic tx_done_i,
  input wire logic tx_fail_i,
  output logic tx_req_valid_o,
  output cwmc_tx_req_t tx_req_o,
  output logic [15:0] tx_stamp_o,
  output logic core_clk_en_o,
  output logic [7:0] nom_bit_clks_o,
  output logic [7:0] data_bit_clks_o,
  output logic [7:0] tdc_offset_o
);
  // control and mode state
  logic [5:0] ctrl_reg;
  cwmc_mode_t mode_reg;
  logic init_request, sleep_request, auto_wakeup_enable;
  logic ttc_en, tx_fifo_order, ts_insert_en;
  // bus pin synchroniser and activity edge
  logic rx_meta_reg, rx_sync_reg, rx_prev_reg;
  logic bus_activity;
  // timer and captured stamps
  logic [15:0] timer_reg, rx_stamp_reg, tx_stamp_reg;
  // mailboxes
  logic [28:0] mb_id_reg [NUM_MB];
  logic [1:0] mb_age_reg [NUM_MB];
  logic [NUM_MB-1:0] mb_pend_reg;
  logic tx_active_reg;
  cwmc_tx_req_t tx_req_reg;
  logic [1:0] best_mb;
  logic any_pend;
  // filters and fifos
  logic [28:0] f_id_reg [NUM_FILT];
  logic [28:0] f_mask_reg [NUM_FILT];
  logic [NUM_FILT-1:0] f_en_reg, f_assign_reg, f_hit;
  logic [4:0] f_sel_reg;
  logic rx_accept, rx_fifo;
  cwmc_rx_entry_t fifo_mem [NUM_FIFO][FIFO_DEPTH];
  logic [1:0] fifo_rd_reg [NUM_FIFO];
  logic [1:0] fifo_cnt_reg [NUM_FIFO];
  logic [NUM_FIFO-1:0] fifo_pop, fifo_push;
  // bit timing configuration
  logic [23:0] bitcfg_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_ctrl, cfg_ok;

  assign init_request = ctrl_reg[CTRL_INIT_BIT];
  assign sleep_request = ctrl_reg[CTRL_SLEEP_BIT];
  assign auto_wakeup_enable = ctrl_reg[CTRL_AWU_BIT];
  assign ttc_en = ctrl_reg[CTRL_TTC_BIT];
  assign tx_fifo_order = ctrl_reg[CTRL_TXFIFO_BIT];
  assign ts_insert_en = ctrl_reg[CTRL_TSINS_BIT];
  assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
  // configuration writes only land in init mode
  assign cfg_ok = (mode_reg == MODE_INIT);

  // stopped clock for the protocol core while asleep
  assign core_clk_en_o = (mode_reg != MODE_SLEEP);

  // two-flop synchroniser on the bus pin; the second stage and a delayed copy of it are looked at
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= can_rx_i;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end
  // a dominant edge counts as bus activity
  assign bus_activity = rx_prev_reg && !rx_sync_reg;

  // control register; software write wins over hardware wake clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata_i[5:0];
    end else if (mode_reg == MODE_SLEEP && auto_wakeup_enable && bus_activity) begin
      ctrl_reg[CTRL_SLEEP_BIT] <= 1'b0;
    end
  end

  // working mode machine
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= MODE_SLEEP;
    end else begin
      case (mode_reg)
        MODE_SLEEP: begin
          if (auto_wakeup_enable && bus_activity) begin
            mode_reg <= init_request ? MODE_INIT : MODE_NORMAL;
          end else if (!sleep_request) begin
            mode_reg <= init_request ? MODE_INIT : MODE_NORMAL;
          end
        end
        MODE_INIT: begin
          if (!init_request) begin
            mode_reg <= sleep_request ? MODE_SLEEP : MODE_NORMAL;
          end
        end
        MODE_NORMAL: begin
          // init has priority; both wait for the current frame to end
          if (init_request && !eng_busy_i) begin
            mode_reg <= MODE_INIT;
          end else if (sleep_request && !eng_busy_i) begin
            mode_reg <= MODE_SLEEP;
          end
        end
        default: begin
          mode_reg <= MODE_SLEEP;
        end
      endcase
    end
  end

  // free-running timer and start-of-frame capture
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_reg <= 16'h0000;
      rx_stamp_reg <= 16'h0000;
      tx_stamp_reg <= 16'h0000;
    end else begin
      timer_reg <= timer_reg + 16'h0001;
      if (rx_sof_i) begin
        rx_stamp_reg <= timer_reg;
      end
      if (tx_sof_i) begin
        tx_stamp_reg <= timer_reg;
      end
    end
  end
  // engine puts this stamp into the last two bytes when asked
  assign tx_stamp_o = tx_stamp_reg;

  // scheduler: lowest identifier, or oldest when in fifo order
  always_comb begin
    best_mb = 2'd0;
    any_pend = 1'b0;
    for (int i = 0; i < NUM_MB; i++) begin
      if (mb_pend_reg[i]) begin
        if (!any_pend) begin
          best_mb = 2'(i);
        end else if (tx_fifo_order ? (mb_age_reg[i] > mb_age_reg[best_mb]) : (mb_id_reg[i] < mb_id_reg[best_mb])) begin
          best_mb = 2'(i);
        end
        any_pend = 1'b1;
      end
    end
  end

  // mailbox contents, pending bits and ages
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mb_pend_reg <= '0;
      for (int i = 0; i < NUM_MB; i++) begin
        mb_id_reg[i] <= 29'h0;
        mb_age_reg[i] <= 2'd0;
      end
    end else begin
      for (int i = 0; i < NUM_MB; i++) begin
        // id may only change while the mailbox is empty
        if (wr_i && addr_i == OFS_TXID0 + 8'(4 * i) && !mb_pend_reg[i]) begin
          mb_id_reg[i] <= wdata_i[28:0];
        end
        if (wr_i && addr_i == OFS_TXCMD && wdata_i[i] && !mb_pend_reg[i]) begin
          mb_pend_reg[i] <= 1'b1;
          mb_age_reg[i] <= 2'd0;
        end else if (wr_i && addr_i == OFS_TXCMD && |wdata_i[NUM_MB-1:0] && mb_age_reg[i] != 2'd3) begin
          mb_age_reg[i] <= mb_age_reg[i] + 2'd1;
        end
        if (tx_active_reg && tx_req_reg.mbox == 2'(i)) begin
          if (tx_done_i || (tx_fail_i && tx_req_reg.no_retx)) begin
            mb_pend_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  // hand one mailbox at a time to the protocol engine
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_active_reg <= 1'b0;
      tx_req_reg <= '0;
    end else if (tx_active_reg) begin
      if (tx_done_i || tx_fail_i) begin
        tx_active_reg <= 1'b0;
      end
    end else if (mode_reg == MODE_NORMAL && !init_request && !sleep_request && any_pend && !eng_busy_i) begin
      tx_active_reg <= 1'b1;
      tx_req_reg.id <= mb_id_reg[best_mb];
      tx_req_reg.mbox <= best_mb;
      tx_req_reg.no_retx <= ttc_en;
      tx_req_reg.ts_insert <= ttc_en && ts_insert_en;
    end
  end
  assign tx_req_valid_o = tx_active_reg;
  assign tx_req_o = tx_req_reg;

  // filter bank match, one comparator per bank
  genvar g;
  generate
    for (g = 0; g < NUM_FILT; g++) begin : g_filt
      assign f_hit[g] = f_en_reg[g] && (((rx_frame_i.id ^ f_id_reg[g]) & f_mask_reg[g]) == 29'h0);
    end
  endgenerate

  // lowest matching bank picks the fifo; no match discards
  always_comb begin
    rx_accept = 1'b0;
    rx_fifo = 1'b0;
    for (int i = NUM_FILT - 1; i >= 0; i--) begin
      if (f_hit[i]) begin
        rx_accept = 1'b1;
        rx_fifo = f_assign_reg[i];
      end
    end
  end

  // filter configuration, writable only in init mode
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      f_sel_reg <= 5'd0;
      f_en_reg <= '0;
      f_assign_reg <= '0;
      for (int i = 0; i < NUM_FILT; i++) begin
        f_id_reg[i] <= 29'h0;
        f_mask_reg[i] <= 29'h0;
      end
    end else if (wr_i && cfg_ok) begin
      if (addr_i == OFS_FSEL && wdata_i[4:0] < 5'(NUM_FILT)) begin
        f_sel_reg <= wdata_i[4:0];
      end
      if (addr_i == OFS_FID) begin
        f_id_reg[f_sel_reg] <= wdata_i[28:0];
      end
      if (addr_i == OFS_FMASK) begin
        f_mask_reg[f_sel_reg] <= wdata_i[28:0];
      end
      if (addr_i == OFS_FEN) begin
        f_en_reg <= wdata_i[NUM_FILT-1:0];
      end
      if (addr_i == OFS_FASSIGN) begin
        f_assign_reg <= wdata_i[NUM_FILT-1:0];
      end
    end
  end

  // data length code to payload bytes; classical frames stop at eight
  function automatic logic [6:0] dlc_bytes(input logic fdf, input logic [3:0] dlc);
    logic [6:0] n;
    n = MAX_CL_BYTES;
    if (dlc <= 4'h8) begin
      n = {3'b000, dlc};
    end else if (fdf) begin
      case (dlc)
        4'h9: n = 7'h0c;
        4'ha: n = 7'h10;
        4'hb: n = 7'h14;
        4'hc: n = 7'h18;
        4'hd: n = 7'h20;
        4'he: n = 7'h30;
        default: n = MAX_FD_BYTES;
      endcase
    end
    return n;
  endfunction

  // push on accepted frames in normal mode, pop on software release
  always_comb begin
    for (int f = 0; f < NUM_FIFO; f++) begin
      fifo_pop[f] = wr_i && addr_i == OFS_RXCTL && wdata_i[f] && fifo_cnt_reg[f] != 2'd0;
      fifo_push[f] = rx_valid_i && rx_accept && rx_fifo == 1'(f) && mode_reg == MODE_NORMAL;
    end
  end

  // three-entry circular fifos; a full fifo drops the new frame
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int f = 0; f < NUM_FIFO; f++) begin
        fifo_rd_reg[f] <= 2'd0;
        fifo_cnt_reg[f] <= 2'd0;
        for (int e = 0; e < FIFO_DEPTH; e++) begin
          fifo_mem[f][e] <= '0;
        end
      end
    end else begin
      for (int f = 0; f < NUM_FIFO; f++) begin
        // a pop frees room for a push in the same cycle
        if (fifo_push[f] && (fifo_cnt_reg[f] != 2'(FIFO_DEPTH) || fifo_pop[f])) begin
          // three-bit sum so pointer plus count cannot wrap before the modulo
          fifo_mem[f][2'((3'(fifo_rd_reg[f]) + 3'(fifo_cnt_reg[f])) % 3'(FIFO_DEPTH))] <=
            '{id: rx_frame_i.id, len: dlc_bytes(rx_frame_i.fdf, rx_frame_i.dlc), stamp: rx_stamp_reg};
          if (!fifo_pop[f]) begin
            fifo_cnt_reg[f] <= fifo_cnt_reg[f] + 2'd1;
          end
        end else if (fifo_pop[f]) begin
          fifo_cnt_reg[f] <= fifo_cnt_reg[f] - 2'd1;
        end
        if (fifo_pop[f]) begin
          fifo_rd_reg[f] <= (fifo_rd_reg[f] == 2'(FIFO_DEPTH - 1)) ? 2'd0 : fifo_rd_reg[f] + 2'd1;
        end
      end
    end
  end

  // bit timing: clocks per bit clamped to the rate limits
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bitcfg_reg <= BITCFG_RESET;
    end else if (wr_i && cfg_ok && addr_i == OFS_BITCFG) begin
      bitcfg_reg[7:0] <= (wdata_i[7:0] < MIN_NOM_CLKS) ? MIN_NOM_CLKS : wdata_i[7:0];
      bitcfg_reg[15:8] <= (wdata_i[15:8] < MIN_DATA_CLKS) ? MIN_DATA_CLKS : wdata_i[15:8];
      bitcfg_reg[23:16] <= wdata_i[23:16];
    end
  end
  assign nom_bit_clks_o = bitcfg_reg[7:0];
  assign data_bit_clks_o = bitcfg_reg[15:8];
  // secondary sample point offset for the fd data phase
  assign tdc_offset_o = bitcfg_reg[23:16];

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0;
    case (addr_i)
      OFS_CTRL: rdata_next = {26'h0, ctrl_reg};
      OFS_STAT: begin
        rdata_next[STAT_INIT_BIT] = (mode_reg == MODE_INIT);
        rdata_next[STAT_SLEEP_BIT] = (mode_reg == MODE_SLEEP);
        rdata_next[STAT_BUSY_BIT] = eng_busy_i;
        rdata_next[STAT_TXACT_BIT] = tx_active_reg;
      end
      OFS_TIMER: rdata_next = {16'h0, timer_reg};
      OFS_TSTAMP: rdata_next = {tx_stamp_reg, rx_stamp_reg};
      OFS_TXID0: rdata_next = {3'h0, mb_id_reg[0]};
      OFS_TXID0 + 8'h04: rdata_next = {3'h0, mb_id_reg[1]};
      OFS_TXID0 + 8'h08: rdata_next = {3'h0, mb_id_reg[2]};
      OFS_TXCMD: rdata_next = {29'h0, mb_pend_reg};
      OFS_RXCTL: rdata_next = {26'h0, fifo_cnt_reg[1], 2'b00, fifo_cnt_reg[0]};
      OFS_RXID0: rdata_next = {3'h0, fifo_mem[0][fifo_rd_reg[0]].id};
      OFS_RXINFO0: rdata_next = {9'h0, fifo_mem[0][fifo_rd_reg[0]].len, fifo_mem[0][fifo_rd_reg[0]].stamp};
      OFS_RXID1: rdata_next = {3'h0, fifo_mem[1][fifo_rd_reg[1]].id};
      OFS_RXINFO1: rdata_next = {9'h0, fifo_mem[1][fifo_rd_reg[1]].len, fifo_mem[1][fifo_rd_reg[1]].stamp};
      OFS_FSEL: rdata_next = {27'h0, f_sel_reg};
      OFS_FEN: rdata_next = {4'h0, f_en_reg};
      OFS_FASSIGN: rdata_next = {4'h0, f_assign_reg};
      OFS_BITCFG: rdata_next = {8'h0, bitcfg_reg};
      default: rdata_next = 32'h0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rd_i ? rdata_next : 32'h0;
    end
  end
  assign rdata_o = rdata_reg;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctrl_write(logic init_v, logic sleep_v);
    wr_ctrl && wdata_i[CTRL_INIT_BIT] == init_v && wdata_i[CTRL_SLEEP_BIT] == sleep_v;
  endsequence
  sequence s_in_init;
    mode_reg == MODE_INIT && !(auto_wakeup_enable && bus_activity);
  endsequence

  AST_SLEEP_CLK_OFF: assert property (mode_reg == MODE_SLEEP |-> !core_clk_en_o)
    else $error("core clock running in sleep");
  AST_INIT_TO_SLEEP: assert property (s_in_init ##0 s_ctrl_write(1'b0, 1'b1) |=> ##1 mode_reg == MODE_SLEEP)
    else $error("init to sleep not taken");
  AST_WAKE: assert property (mode_reg == MODE_SLEEP && auto_wakeup_enable && bus_activity && !wr_ctrl
                             |=> mode_reg != MODE_SLEEP && !sleep_request)
    else $error("auto wakeup missed");
  AST_SLEEP_EXIT: assert property (mode_reg == MODE_SLEEP && !sleep_request && init_request
                                   |=> mode_reg == MODE_INIT)
    else $error("sleep to init missed");
  AST_HOLD_BUSY: assert property (mode_reg == MODE_NORMAL && eng_busy_i |=> mode_reg == MODE_NORMAL)
    else $error("left normal mid frame");
  AST_FLAGS: assert property (rd_i && addr_i == OFS_STAT
                              |=> rdata_o[STAT_INIT_BIT] == ($past(mode_reg) == MODE_INIT)
                                  && rdata_o[STAT_SLEEP_BIT] == ($past(mode_reg) == MODE_SLEEP))
    else $error("status flags wrong");
  AST_NO_RETX: assert property (tx_active_reg && tx_fail_i && tx_req_reg.no_retx
                                |=> !mb_pend_reg[$past(tx_req_reg.mbox)])
    else $error("retransmit kept in ttc");
  AST_STAMP: assert property (rx_sof_i |=> rx_stamp_reg == $past(timer_reg))
    else $error("sof stamp wrong");
  AST_FIFO_DEPTH: assert property ((fifo_cnt_reg[0] == 2'd3 && !fifo_pop[0] |=> fifo_cnt_reg[0] == 2'd3)
                                   and (fifo_cnt_reg[1] == 2'd3 && !fifo_pop[1] |=> fifo_cnt_reg[1] == 2'd3))
    else $error("fifo count wrapped past full");
  AST_NOM_RATE: assert property (nom_bit_clks_o >= MIN_NOM_CLKS && data_bit_clks_o >= MIN_DATA_CLKS)
    else $error("bit rate above limit");
endmodule
`default_nettype wire

// [src/cwmc_pkg.sv]
`default_nettype none
package cwmc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TIMER = 8'h08;
  localparam logic [7:0] OFS_TSTAMP = 8'h0c;
  localparam logic [7:0] OFS_TXID0 = 8'h10;
  localparam logic [7:0] OFS_TXCMD = 8'h1c;
  localparam logic [7:0] OFS_RXCTL = 8'h20;
  localparam logic [7:0] OFS_RXID0 = 8'h24;
  localparam logic [7:0] OFS_RXINFO0 = 8'h28;
  localparam logic [7:0] OFS_RXID1 = 8'h2c;
  localparam logic [7:0] OFS_RXINFO1 = 8'h30;
  localparam logic [7:0] OFS_FSEL = 8'h34;
  localparam logic [7:0] OFS_FID = 8'h38;
  localparam logic [7:0] OFS_FMASK = 8'h3c;
  localparam logic [7:0] OFS_FEN = 8'h40;
  localparam logic [7:0] OFS_FASSIGN = 8'h44;
  localparam logic [7:0] OFS_BITCFG = 8'h48;
  // control register field positions
  localparam int unsigned CTRL_INIT_BIT = 0;
  localparam int unsigned CTRL_SLEEP_BIT = 1;
  localparam int unsigned CTRL_AWU_BIT = 2;
  localparam int unsigned CTRL_TTC_BIT = 3;
  localparam int unsigned CTRL_TXFIFO_BIT = 4;
  localparam int unsigned CTRL_TSINS_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h02;
  // status register field positions
  localparam int unsigned STAT_INIT_BIT = 0;
  localparam int unsigned STAT_SLEEP_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;
  localparam int unsigned STAT_TXACT_BIT = 3;
  // capabilities
  localparam int unsigned NUM_MB = 3;
  localparam int unsigned NUM_FIFO = 2;
  localparam int unsigned FIFO_DEPTH = 3;
  localparam int unsigned NUM_FILT = 28;
  localparam logic [6:0] MAX_FD_BYTES = 7'h40;
  localparam logic [6:0] MAX_CL_BYTES = 7'h08;
  // bit rate limits
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLASSIC_MAX_BPS = 1_000_000;
  localparam int unsigned FD_MAX_BPS = 6_000_000;
  localparam logic [7:0] MIN_NOM_CLKS = 8'((CLK_HZ + CLASSIC_MAX_BPS - 1) / CLASSIC_MAX_BPS);
  localparam logic [7:0] MIN_DATA_CLKS = 8'((CLK_HZ + FD_MAX_BPS - 1) / FD_MAX_BPS);
  localparam logic [23:0] BITCFG_RESET = 24'h001414;
  typedef enum logic [1:0] {MODE_SLEEP, MODE_INIT, MODE_NORMAL} cwmc_mode_t;
  typedef struct packed {
    logic [28:0] id;
    logic fdf;
    logic [3:0] dlc;
  } cwmc_rx_frame_t;
  typedef struct packed {
    logic [28:0] id;
    logic [1:0] mbox;
    logic no_retx;
    logic ts_insert;
  } cwmc_tx_req_t;
  typedef struct packed {
    logic [28:0] id;
    logic [6:0] len;
    logic [15:0] stamp;
  } cwmc_rx_entry_t;
endpackage
`default_nettype wire

// [test/cwmc_can_node.sv]
`default_nettype none
// far side: protocol engine and bus stand-in
module cwmc_can_node
  import cwmc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic tx_req_valid_i,
  output logic can_rx_o,
  output logic eng_busy_o,
  output logic rx_sof_o,
  output logic tx_sof_o,
  output logic rx_valid_o,
  output cwmc_rx_frame_t rx_frame_o,
  output logic tx_done_o,
  output logic tx_fail_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_hold = 1'b0; // set by bench to stretch a frame
  logic fail_mode = 1'b0; // answer failure instead of success
  int cnt = 0;
  // busy while a frame is on the wire
  assign eng_busy_o = busy_hold | tx_req_valid_i;
  initial begin
    can_rx_o = 1'b1;
    rx_sof_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
  end
  // answer a handed-over mailbox after a fixed frame time
  always @(posedge sys_clk_i) begin
    tx_sof_o <= 1'b0;
    tx_done_o <= 1'b0;
    tx_fail_o <= 1'b0;
    if (tx_req_valid_i && !tx_done_o && !tx_fail_o) begin
      cnt <= cnt + 1;
      if (cnt == 1) tx_sof_o <= 1'b1;
      if (cnt == 5) begin
        cnt <= 0;
        tx_done_o <= !fail_mode;
        tx_fail_o <= fail_mode;
      end
    end
  end
  // one received frame; data lines scrambled outside the valid cycle
  task automatic send(input logic [28:0] id, input logic fdf, input logic [3:0] dlc);
    @(posedge sys_clk_i) rx_sof_o <= 1'b1;
    @(posedge sys_clk_i) rx_sof_o <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rx_valid_o <= 1'b1;
    rx_frame_o <= '{id: id, fdf: fdf, dlc: dlc};
    @(posedge sys_clk_i) rx_valid_o <= 1'b0;
    rx_frame_o <= ~rx_frame_o;
  endtask
  // dominant pulse on the bus pin
  task automatic wake();
    @(posedge sys_clk_i) can_rx_o <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    can_rx_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [test/test_can_working_mode_control.sv]
`default_nettype none
module test_can_working_mode_control
  import cwmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic can_rx, busy, rsof, tsof, rval, tdone, tfail, tval, clk_en;
  cwmc_rx_frame_t rfr;
  cwmc_tx_req_t treq;
  logic [15:0] tstamp;
  logic [7:0] nom, dat, tdc;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int stamp_ofs = 0; // timer value minus cycle count
  int tsof_cyc = 0; // cycle of the last transmit start of frame
  int rsof_cyc = 0; // cycle of the last receive start of frame
  logic [1:0] order[$]; // mailbox hand-over order
  logic prev_val = 1'b0;
  logic [31:0] d, t1;
  cwmc_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .can_rx_i(can_rx), .eng_busy_i(busy),
    .rx_sof_i(rsof), .tx_sof_i(tsof), .rx_valid_i(rval), .rx_frame_i(rfr), .tx_done_i(tdone),
    .tx_fail_i(tfail), .tx_req_valid_o(tval), .tx_req_o(treq), .tx_stamp_o(tstamp),
    .core_clk_en_o(clk_en), .nom_bit_clks_o(nom), .data_bit_clks_o(dat), .tdc_offset_o(tdc));
  cwmc_can_node part (.sys_clk_i(sys_clk_i), .tx_req_valid_i(tval), .can_rx_o(can_rx),
    .eng_busy_o(busy), .rx_sof_o(rsof), .tx_sof_o(tsof), .rx_valid_o(rval), .rx_frame_o(rfr),
    .tx_done_o(tdone), .tx_fail_o(tfail));
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // record each new hand-over; hang guard
  always @(posedge sys_clk_i) begin
    prev_val <= tval;
    if (tval === 1'b1 && prev_val === 1'b0) order.push_back(treq.mbox);
    // cycle of each start of frame, for the stamp checks
    if (tsof === 1'b1) tsof_cyc <= cyc;
    if (rsof === 1'b1) rsof_cyc <= cyc;
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i) wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge sys_clk_i) wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i) rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i) rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // status read compared against expected mode flags
  task automatic stat(input logic [31:0] exp);
    rd(OFS_STAT, d);
    check(d, exp);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(8'h00, d);
    check(d, 32'h2);
    stat(32'h2);
    check({31'h0, clk_en}, 32'h0);
    wr(OFS_BITCFG, 32'h00070319);
    check({24'h0, nom}, 32'h14);
    $display("reset test done");
    wr(8'h00, 32'h1);
    stat(32'h1);
    check({31'h0, clk_en}, 32'h1);
    wr(OFS_BITCFG, 32'h00070319);
    #1 check({tdc, dat, nom}, 32'h070419);
    wr(OFS_FSEL, 32'h0);
    wr(OFS_FID, 32'h100);
    wr(OFS_FMASK, 32'h1fffffff);
    wr(OFS_FEN, 32'h1);
    wr(OFS_FASSIGN, 32'h0);
    wr(8'h00, 32'h0);
    stat(32'h0);
    wr(OFS_BITCFG, 32'h00000030);
    check({24'h0, nom}, 32'h19);
    $display("config test done");
    part.send(29'h100, 1'b1, 4'hf);
    part.send(29'h101, 1'b0, 4'h8);
    repeat (3) part.send(29'h100, 1'b0, 4'h8);
    rd(OFS_RXCTL, d);
    check(d & 32'h33, 32'h3);
    rd(OFS_RXID0, d);
    check(d, 32'h100);
    rd(OFS_RXINFO0, d);
    check(d & 32'h7f0000, 32'h400000);
    wr(OFS_RXCTL, 32'h1);
    rd(OFS_RXCTL, d);
    check(d & 32'h33, 32'h2);
    rd(OFS_RXINFO0, d);
    check(d & 32'h7f0000, 32'h080000);
    $display("receive test done");
    rd(OFS_TIMER, t1);
    // timer and cycle counter differ by a constant once reset is gone
    stamp_ofs = int'(t1[15:0]) - cyc + 1;
    repeat (3) @(posedge sys_clk_i);
    rd(OFS_TIMER, d);
    check({16'h0, d[15:0] - t1[15:0]}, 32'h5);
    wr(OFS_TXID0, 32'h20);
    wr(OFS_TXID0 + 8'h04, 32'h10);
    wr(OFS_TXID0 + 8'h08, 32'h10);
    wr(OFS_TXCMD, 32'h7);
    for (int i = 0; i < 200 && order.size() < 3; i++) @(posedge sys_clk_i);
    check({order.size(), order[0], order[1], order[2]}, {32'h3, 6'b01_10_00});
    $display("transmit order test done");
    order.delete();
    part.fail_mode <= 1'b1;
    wr(8'h00, 32'h28);
    wr(OFS_TXCMD, 32'h1);
    @(posedge tval) #1 check({treq.id, treq.no_retx, treq.ts_insert}, {29'h20, 2'b11});
    repeat (60) @(posedge sys_clk_i);
    check(order.size(), 32'h1);
    part.fail_mode <= 1'b0;
    check({16'h0, tstamp}, 32'(tsof_cyc + stamp_ofs));
    rd(OFS_TSTAMP, d);
    check(d, {16'(tsof_cyc + stamp_ofs), 16'(rsof_cyc + stamp_ofs)});
    $display("time-triggered test done");
    // fifo order: oldest pending mailbox goes first, whatever its id
    order.delete();
    part.busy_hold <= 1'b1;
    wr(8'h00, 32'h10);
    wr(OFS_TXCMD, 32'h4);
    wr(OFS_TXCMD, 32'h1);
    wr(OFS_TXCMD, 32'h2);
    part.busy_hold <= 1'b0;
    for (int i = 0; i < 200 && order.size() < 3; i++) @(posedge sys_clk_i);
    check({order.size(), order[0], order[1], order[2]}, {32'h3, 6'b10_00_01});
    $display("fifo order test done");
    part.busy_hold <= 1'b1;
    wr(8'h00, 32'h1);
    repeat (5) @(posedge sys_clk_i);
    stat(32'h4);
    part.busy_hold <= 1'b0;
    stat(32'h1);
    wr(8'h00, 32'h2);
    stat(32'h2);
    check({31'h0, clk_en}, 32'h0);
    wr(8'h00, 32'h0);
    stat(32'h0);
    part.busy_hold <= 1'b1;
    wr(8'h00, 32'h2);
    repeat (5) @(posedge sys_clk_i);
    stat(32'h4);
    part.busy_hold <= 1'b0;
    stat(32'h2);
    $display("mode change test done");
    wr(8'h00, 32'h6);
    stat(32'h2);
    part.wake();
    repeat (10) @(posedge sys_clk_i);
    stat(32'h0);
    rd(8'h00, d);
    check(d & 32'h7, 32'h4);
    $display("wake-up test done");
    close_out();
  end
endmodule
`default_nettype wire
